// ===== design/sysr_defines.vh
// constants for the sysref capture and duty-cycle stabilizer control bank
`ifndef SYSR_DEFINES_VH
`define SYSR_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SYSR_ADDR_W          12
`define SYSR_OFS_STAB_TWO    12'h11e
`define SYSR_OFS_STAB_THREE  12'h11f
`define SYSR_OFS_CAPT_ONE    12'h120
`define SYSR_OFS_IGNORE      12'h121
`define SYSR_OFS_TS_DELAY    12'h123
`define SYSR_OFS_EVT_COUNT   12'h12a
`define SYSR_OFS_SYNC_MODE   12'h1ff

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SYSR_RST_STAB_TWO    8'h88
`define SYSR_RST_STAB_THREE  8'h84
`define SYSR_RST_CAPT_ONE    8'h00
`define SYSR_RST_IGNORE      4'h0
`define SYSR_RST_TS_DELAY    7'h40
`define SYSR_RST_SYNC_MODE   1'h0

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define SYSR_STAB_PWR_BIT    0
`define SYSR_STAB_EN_BIT     1
`define SYSR_STAB_RSV_HI     7
`define SYSR_STAB_RSV_LO     3
`define SYSR_STAB3_BYPASS    8'h84
`define SYSR_STAB3_ENABLE    8'h81
`define SYSR_FLAG_RST_BIT    6
`define SYSR_TRANS_BIT       4
`define SYSR_EDGE_BIT        3
`define SYSR_MODE_HI         2
`define SYSR_MODE_LO         1
`define SYSR_MODE_OFF        2'h0
`define SYSR_MODE_CONT       2'h1
`define SYSR_MODE_NSHOT      2'h2

`endif

// ===== design/sysr_capture.v
// sysref transition detector with continuous and n-shot qualification
`default_nettype none

module sysr_capture (
    input  wire       clk,
    input  wire       rstn,
    input  wire       sample,
    input  wire       falling_valid,
    input  wire [1:0] mode,
    input  wire [3:0] ignore_count,
    output reg        capture
);
`include "sysr_defines.vh"

    // ----------------------------------------------------------------
    // n-shot states
    // ----------------------------------------------------------------
    localparam ST_SKIP = 3'h1;
    localparam ST_ARM  = 3'h2;
    localparam ST_DONE = 3'h4;

    reg        prev;
    reg  [2:0] state;
    reg  [2:0] next_state;
    reg  [3:0] skipped;
    reg  [3:0] next_skipped;
    reg        next_capture;
    wire       valid;

    // polarity picks which transition counts; see (RULE_05)
    assign valid = falling_valid ? (prev & ~sample) : (~prev & sample);

    always @* begin
        next_state   = state;
        next_skipped = skipped;
        next_capture = 1'b0;
        case (mode)
            `SYSR_MODE_CONT: begin
                next_capture = valid; // see (RULE_08)
                next_state   = ST_SKIP;
                next_skipped = 4'h0;
            end
            `SYSR_MODE_NSHOT: begin
                case (state)
                    ST_SKIP: begin
                        // skip the programmed number first; see (RULE_09)
                        if (skipped == ignore_count) begin
                            if (valid) begin
                                next_capture = 1'b1;
                                next_state   = ST_DONE;
                            end else begin
                                next_state = ST_ARM;
                            end
                        end else if (valid) begin
                            next_skipped = skipped + 4'h1;
                        end
                    end
                    ST_ARM: begin
                        if (valid) begin
                            next_capture = 1'b1;
                            next_state   = ST_DONE;
                        end
                    end
                    ST_DONE: begin
                        next_state = ST_DONE;
                    end
                    default: begin
                        next_state = ST_SKIP;
                    end
                endcase
            end
            default: begin
                // disabled or reserved code: capture nothing, re-arm; see (RULE_08)
                next_state   = ST_SKIP;
                next_skipped = 4'h0;
            end
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev    <= 1'b0;
            state   <= ST_SKIP;
            skipped <= 4'h0;
            capture <= 1'b0;
        end else begin
            prev    <= sample;
            state   <= next_state;
            skipped <= next_skipped;
            capture <= next_capture;
        end
    end

endmodule

`default_nettype wire

// ===== design/sysr_regs.v
// sysref capture and duty-cycle stabilizer control register bank
//
// Behaviour
// (RULE_01) Stabilizer two has power-up in bit 0 and enable in bit 1, and it only runs when powered and enabled.
// (RULE_02) Software writes stabilizer two with the same value as stabilizer one so both stages match.
// (RULE_03) Stabilizer three is a full-byte code where 0x84 bypasses (the reset value) and 0x81 enables.
// (RULE_04) Flag-reset bit 6 holds the capture flags cleared while set and lets them run while clear.
// (RULE_05) Transition-select bit 4 makes rising sysref valid at 0 and falling sysref valid at 1.
// (RULE_06) Software disables capture mode before changing the transition polarity.
// (RULE_07) Edge-select bit 3 samples sysref on the rising clock edge at 0 and the falling edge at 1.
// (RULE_08) Mode field bits 2:1 gives 00 disabled, 01 continuous and 10 n-shot capture.
// (RULE_09) N-shot mode skips the four-bit ignore count of valid transitions and acts on the next one.
// (RULE_10) A seven-bit timestamp delay of 0 to 127 sample cycles, reset 0x40, delays the capture mark.
// (RULE_11) An eight-bit count of captured events wraps after 255 and is cleared by the flag-reset bit.
// (RULE_12) Sample sync mode resets the dividers on capture, while partial mode only timestamps a sample.
`default_nettype none

module sysr_regs (
    input  wire        clk,
    input  wire        rstn,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [11:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    input  wire        sysref_pin,
    output reg         stab_two_power_up,
    output reg         stab_two_enable,
    output reg         stab_three_enable,
    output reg         flags_hold_reset,
    output reg         capture_flag,
    output reg         divider_reset,
    output reg         timestamp_mark
);
`include "sysr_defines.vh"

    // reset image of the capture control byte, so single fields can be picked from it
    localparam [7:0] RST_CAPT_ONE = `SYSR_RST_CAPT_ONE;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    reg  [7:0] stab_two;
    reg  [7:0] stab_three;
    reg        flag_reset;
    reg        trans_falling;
    reg        edge_falling;
    reg  [1:0] capt_mode;
    reg  [3:0] ignore_count;
    reg  [6:0] ts_delay;
    reg        sync_partial;
    reg  [7:0] evt_count;

    wire wr_stab_two   = reg_wr && (reg_addr == `SYSR_OFS_STAB_TWO);
    wire wr_stab_three = reg_wr && (reg_addr == `SYSR_OFS_STAB_THREE);
    wire wr_capt_one   = reg_wr && (reg_addr == `SYSR_OFS_CAPT_ONE);
    wire wr_ignore     = reg_wr && (reg_addr == `SYSR_OFS_IGNORE);
    wire wr_ts_delay   = reg_wr && (reg_addr == `SYSR_OFS_TS_DELAY);
    wire wr_sync_mode  = reg_wr && (reg_addr == `SYSR_OFS_SYNC_MODE);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stab_two      <= `SYSR_RST_STAB_TWO;
            stab_three    <= `SYSR_RST_STAB_THREE;
            flag_reset    <= RST_CAPT_ONE[`SYSR_FLAG_RST_BIT];
            trans_falling <= 1'b0;
            edge_falling  <= 1'b0;
            capt_mode     <= `SYSR_MODE_OFF;
            ignore_count  <= `SYSR_RST_IGNORE;
            ts_delay      <= `SYSR_RST_TS_DELAY; // see (RULE_10)
            sync_partial  <= `SYSR_RST_SYNC_MODE;
        end else begin
            if (wr_stab_two) begin
                // bit 2 is not a field and reads zero; mirroring stabilizer one is
                // left to software, see (RULE_02)
                stab_two <= reg_wdata & 8'hfb;
            end
            if (wr_stab_three) begin
                stab_three <= reg_wdata;
            end
            if (wr_capt_one) begin
                flag_reset    <= reg_wdata[`SYSR_FLAG_RST_BIT];
                // polarity is taken as written; changing it with capture on
                // may fake one edge, see (RULE_06)
                trans_falling <= reg_wdata[`SYSR_TRANS_BIT];
                edge_falling  <= reg_wdata[`SYSR_EDGE_BIT];
                capt_mode     <= reg_wdata[`SYSR_MODE_HI:`SYSR_MODE_LO];
            end
            if (wr_ignore) begin
                ignore_count <= reg_wdata[3:0];
            end
            if (wr_ts_delay) begin
                ts_delay <= reg_wdata[6:0];
            end
            if (wr_sync_mode) begin
                sync_partial <= reg_wdata[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // read port, one cycle latency, unmapped reads return zero
    // ----------------------------------------------------------------
    reg [7:0] next_rdata;

    always @* begin
        case (reg_addr)
            `SYSR_OFS_STAB_TWO:   next_rdata = stab_two;
            `SYSR_OFS_STAB_THREE: next_rdata = stab_three;
            `SYSR_OFS_CAPT_ONE:   next_rdata = {1'b0, flag_reset, 1'b0, trans_falling,
                                                edge_falling, capt_mode, 1'b0};
            `SYSR_OFS_IGNORE:     next_rdata = {4'h0, ignore_count};
            `SYSR_OFS_TS_DELAY:   next_rdata = {1'b0, ts_delay};
            `SYSR_OFS_EVT_COUNT:  next_rdata = evt_count;
            `SYSR_OFS_SYNC_MODE:  next_rdata = {7'h00, sync_partial};
            default:              next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // stabilizer controls
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stab_two_power_up <= 1'b0;
            stab_two_enable   <= 1'b0;
            stab_three_enable <= 1'b0;
        end else begin
            stab_two_power_up <= stab_two[`SYSR_STAB_PWR_BIT];
            // an enabled but unpowered stage stays bypassed; see (RULE_01)
            stab_two_enable   <= stab_two[`SYSR_STAB_EN_BIT] & stab_two[`SYSR_STAB_PWR_BIT];
            // any code other than the enable code leaves the stage bypassed; see (RULE_03)
            stab_three_enable <= (stab_three == `SYSR_STAB3_ENABLE);
        end
    end

    // ----------------------------------------------------------------
    // sysref sampling on either clock edge
    // ----------------------------------------------------------------
    reg rise_sync1;
    reg rise_sync2;
    reg fall_sync1;
    reg fall_sync2;

    // falling path lands its first stage on the low phase, then retimes once on the rising edge
    always @(negedge clk or negedge rstn) begin
        if (!rstn) begin
            fall_sync1 <= 1'b0;
        end else begin
            fall_sync1 <= sysref_pin;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rise_sync1 <= 1'b0;
            rise_sync2 <= 1'b0;
            fall_sync2 <= 1'b0;
        end else begin
            rise_sync1 <= sysref_pin;
            rise_sync2 <= rise_sync1;
            fall_sync2 <= fall_sync1;
        end
    end

    // pick the sampling edge; see (RULE_07)
    wire sysref_sample = edge_falling ? fall_sync2 : rise_sync2;
    wire capture;

    sysr_capture u_capture (
        .clk           (clk),
        .rstn          (rstn),
        .sample        (sysref_sample),
        .falling_valid (trans_falling),
        .mode          (capt_mode),
        .ignore_count  (ignore_count),
        .capture       (capture)
    );

    // ----------------------------------------------------------------
    // flags, event count and timestamp delay
    // ----------------------------------------------------------------
    reg       delay_busy;
    reg [6:0] delay_left;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_hold_reset <= 1'b0;
            capture_flag     <= 1'b0;
            evt_count        <= 8'h00;
        end else begin
            flags_hold_reset <= flag_reset; // see (RULE_04)
            if (flag_reset) begin
                capture_flag <= 1'b0; // see (RULE_04)
                evt_count    <= 8'h00; // see (RULE_11)
            end else if (capture) begin
                capture_flag <= 1'b1;
                evt_count    <= evt_count + 8'h01; // wraps past 255, see (RULE_11)
            end
        end
    end

    // a new capture during a pending delay restarts it rather than queueing
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            delay_busy     <= 1'b0;
            delay_left     <= 7'h00;
            divider_reset  <= 1'b0;
            timestamp_mark <= 1'b0;
        end else begin
            divider_reset  <= 1'b0;
            timestamp_mark <= 1'b0;
            if (capture) begin
                delay_busy <= 1'b1;
                delay_left <= ts_delay; // see (RULE_10)
            end else if (delay_busy) begin
                if (delay_left == 7'h00) begin
                    delay_busy     <= 1'b0;
                    timestamp_mark <= 1'b1;
                    divider_reset  <= ~sync_partial; // see (RULE_12)
                end else begin
                    delay_left <= delay_left - 7'h01;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ===== verif/sysr_regs_sva.sv
// assertion checker on the ports of the sysref control bank
`default_nettype none
module sysr_regs_sva (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        sysref_pin,
    input wire logic        stab_two_power_up,
    input wire logic        stab_two_enable,
    input wire logic        stab_three_enable,
    input wire logic        flags_hold_reset,
    input wire logic        capture_flag,
    input wire logic        divider_reset,
    input wire logic        timestamp_mark
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // write decodes; a write to the same place in the next cycle voids the check
    // ----------------------------------------------------------------
    wire w2 = reg_wr && reg_addr == 12'h11e;
    wire w3 = reg_wr && reg_addr == 12'h11f;
    wire w0 = reg_wr && reg_addr == 12'h120;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    AST_S2_OFF: assert property ((w2 && !reg_wdata[0] ##1 !w2) |=> !stab_two_enable)
        else $error("stage two enabled while powered down");
    AST_S2_PWR: assert property (stab_two_enable |-> stab_two_power_up)
        else $error("stage two enabled without power");
    AST_S3_ON: assert property ((w3 && reg_wdata == 8'h81 ##1 !w3) |=> stab_three_enable)
        else $error("stage three not enabled by its code");
    AST_S3_BYP: assert property ((w3 && reg_wdata != 8'h81 ##1 !w3) |=> !stab_three_enable)
        else $error("stage three not bypassed");
    AST_HOLD: assert property ((w0 && reg_wdata[6] ##1 !w0) |=> flags_hold_reset)
        else $error("flag hold missing after write");
    AST_FLAG_CLR: assert property (flags_hold_reset |=> !capture_flag)
        else $error("capture flag set during flag hold");
    AST_MARK_DUE: assert property ($rose(capture_flag) |-> ##[1:129] timestamp_mark)
        else $error("timestamp mark late");
    AST_DIV_MARK: assert property (divider_reset |-> timestamp_mark)
        else $error("divider reset without mark");
    AST_RD_ACK: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    AST_RD_HOLD: assert property (!reg_rvalid |-> $stable(reg_rdata) && $past(reg_rd) == 1'b0)
        else $error("read data moved without a read");
endmodule
`default_nettype wire

// ===== verif/sysr_sysref_gen.sv
// clock generator side model driving the sysref pulse train
`default_nettype none
module sysr_sysref_gen (
    input  wire logic clk,
    output var  logic sysref
);
    timeunit 1ns;
    timeprecision 1ps;
    initial sysref = 1'b0;
    // idle low between pulses; each level is held at least hi cycles so the sync flops see it
    task automatic send(input int n, input int hi);
        repeat (n) begin
            @(posedge clk);
            #1;
            sysref = 1'b1;
            repeat (hi) @(posedge clk);
            #1;
            sysref = 1'b0;
            repeat (hi) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ===== verif/sysref_capture_and_dcs_control_test.sv
// self-checking bench for the sysref capture and stabilizer control bank
`default_nettype none
module sysref_capture_and_dcs_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00;
    wire  [7:0]  reg_rdata;
    wire         reg_rvalid, sysref_pin, s2p, s2e, s3e, hold, cflag, divr, mark;
    int          bad_count = 0, total_checks = 0, cyc = 0, marks = 0, divs = 0;
    int          last_mark = 0, t0, lat0, lat, cnt;
    sysr_regs i_dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sysref_pin(sysref_pin), .stab_two_power_up(s2p),
        .stab_two_enable(s2e), .stab_three_enable(s3e), .flags_hold_reset(hold),
        .capture_flag(cflag), .divider_reset(divr), .timestamp_mark(mark));
    sysr_sysref_gen i_gen (.clk(clk), .sysref(sysref_pin));
    always #5 clk = ~clk;
    // ----------------------------------------------------------------
    // event counting and hang guard
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (mark === 1'b1) begin
            marks++;
            last_mark = cyc;
        end
        if (divr === 1'b1) divs++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        chk("rvalid", 8'h01, {7'h0, reg_rvalid});
        chk(name, exp, reg_rdata);
    endtask
    // pin change to mark; the fixed pipeline part cancels in a difference
    task lat_of(input logic [6:0] d, output int l);
        int lim;
        lim = 0;
        wr(12'h123, {1'b0, d});
        marks = 0;
        t0 = cyc;
        i_gen.send(1, 2);
        while (marks == 0 && lim < 200) begin
            idle(1);
            lim++;
        end
        l = last_mark - t0;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        idle(5);
        rstn = 1'b1;
        rd(12'h11e, 8'h88, "stab_two");
        rd(12'h11f, 8'h84, "stab_three");
        rd(12'h120, 8'h00, "capt_one");
        rd(12'h121, 8'h00, "ignore");
        rd(12'h123, 8'h40, "ts_delay");
        rd(12'h12a, 8'h00, "evt_count");
        rd(12'h122, 8'h00, "unmapped");
        $display("test reset_values done");
        wr(12'h11e, 8'h02);
        idle(2);
        chk("stab_two_en", 8'h00, {7'h0, s2e});
        wr(12'h11e, 8'hff);
        idle(2);
        chk("stab_two_on", 8'h03, {6'h0, s2e, s2p});
        rd(12'h11e, 8'hfb, "stab_two");
        wr(12'h11f, 8'h81);
        idle(2);
        chk("stab_three_on", 8'h01, {7'h0, s3e});
        wr(12'h11f, 8'h80);
        idle(2);
        chk("stab_three_off", 8'h00, {7'h0, s3e});
        wr(12'h120, 8'hff);
        rd(12'h120, 8'h5e, "capt_one");
        chk("hold", 8'h01, {7'h0, hold});
        wr(12'h121, 8'hff);
        rd(12'h121, 8'h0f, "ignore");
        wr(12'h123, 8'hff);
        rd(12'h123, 8'h7f, "ts_delay");
        wr(12'h12a, 8'h55);
        wr(12'h120, 8'h58);
        wr(12'h120, 8'h00);
        wr(12'h121, 8'h00);
        wr(12'h123, 8'h00);
        rd(12'h12a, 8'h00, "evt_ro");
        $display("test register_access done");
        // every mode code; n-shot with no ignore acts once
        cnt = 0;
        marks = 0;
        for (int m = 0; m < 4; m++) begin
            wr(12'h120, {5'h0, m[1:0], 1'b0});
            i_gen.send(2, 3);
            idle(8);
            wr(12'h120, 8'h00);
            cnt += (m == 1) ? 2 : (m == 2) ? 1 : 0;
        end
        rd(12'h12a, cnt[7:0], "evt_modes");
        chk("marks", 8'd3, marks[7:0]);
        chk("div_resets", 8'd3, divs[7:0]);
        chk("capture_flag", 8'h01, {7'h0, cflag});
        wr(12'h120, 8'h18);
        wr(12'h120, 8'h1a);
        i_gen.send(2, 3);
        idle(8);
        wr(12'h120, 8'h18);
        wr(12'h120, 8'h00);
        rd(12'h12a, 8'd5, "evt_falling");
        $display("test capture_modes done");
        wr(12'h121, 8'h0f);
        wr(12'h120, 8'h04);
        i_gen.send(17, 3);
        idle(8);
        wr(12'h120, 8'h00);
        rd(12'h12a, 8'd6, "nshot_15");
        wr(12'h121, 8'h02);
        wr(12'h120, 8'h04);
        marks = 0;
        i_gen.send(2, 3);
        idle(8);
        chk("skipped", 8'd0, marks[7:0]);
        i_gen.send(2, 3);
        idle(8);
        chk("acted", 8'd1, marks[7:0]);
        wr(12'h120, 8'h00);
        $display("test nshot done");
        wr(12'h1ff, 8'h01);
        rd(12'h1ff, 8'h01, "sync_mode");
        marks = 0;
        divs = 0;
        wr(12'h120, 8'h02);
        i_gen.send(2, 3);
        idle(8);
        chk("partial_marks", 8'd2, marks[7:0]);
        chk("partial_divs", 8'd0, divs[7:0]);
        wr(12'h1ff, 8'h00);
        lat_of(7'd0, lat0);
        lat_of(7'd5, lat);
        chk("delay5", 8'd5, 8'(lat - lat0));
        lat_of(7'd127, lat);
        chk("delay127", 8'd127, 8'(lat - lat0));
        wr(12'h120, 8'h00);
        rd(12'h12a, 8'd12, "evt_sync");
        $display("test sync_and_delay done");
        wr(12'h120, 8'h40);
        idle(2);
        chk("flag_cleared", 8'h00, {7'h0, cflag});
        rd(12'h12a, 8'h00, "evt_cleared");
        wr(12'h120, 8'h42);
        i_gen.send(1, 3);
        idle(8);
        wr(12'h120, 8'h40);
        rd(12'h12a, 8'h00, "evt_held");
        chk("flag_held", 8'h00, {7'h0, cflag});
        wr(12'h123, 8'h00);
        wr(12'h120, 8'h02);
        i_gen.send(257, 2);
        idle(8);
        wr(12'h120, 8'h00);
        rd(12'h12a, 8'h01, "evt_wrap");
        chk("flag_set", 8'h01, {7'h0, cflag});
        $display("test flag_reset_and_wrap done");
        tally_and_finish;
    end
endmodule
bind sysr_regs sysr_regs_sva i_sva (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sysref_pin(sysref_pin), .stab_two_power_up(stab_two_power_up),
    .stab_two_enable(stab_two_enable), .stab_three_enable(stab_three_enable),
    .flags_hold_reset(flags_hold_reset), .capture_flag(capture_flag),
    .divider_reset(divider_reset), .timestamp_mark(timestamp_mark));
`default_nettype wire
